// *** fcui_top.sv ***
// Functional notes
// - Reset and command FF select array read until another command.
// - FF ignored while an unsuspended erase or program runs.
// - Erase is 20 then D0; any address in sector names the sector.
// - Either 40 or 10 starts a byte program.
// - Program address and data come from the second write.
// - Programming only clears bits; erase sets them to one.
// - Locked or pin-protected sector fails the operation, status shows why.
// - After a program sequence reads return status.
// - Verify error only when a bit meant to be zero stays one.
// - B0 during erase halts at an algorithm step; reads give status.
// - Erase suspended accepts array read, other-sector program, status, resume.
// - Resume D0 continues erase only after a nested program ends.
// - Program suspended accepts array read, status, clear status (50), resume only.
// - Command 90 gives maker code at 0, device code at 1.
// - Command 70 makes reads return status until next valid command.
// - Error flags set only by the engine, cleared only by 50.
// - No whole-array erase exists; erase is per sector.
// - Status bit7 ready, 6 erase susp, 5/4 errors, 2 prog susp, 1 protect.
// - An improper erase sequence (20 not followed by D0) sets both erase and program error bits.
//
// Our own choices: the register addresses and the APB interface to the registers.
module fcui_top #(
   parameter int SECTORS    = 16,
   parameter int SECT_BITS  = 16,
   parameter int ARRAY_BITS = 20
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        top_sector_protect_pin_n,
   input  wire logic        other_sector_protect_pin_n,
   output logic             ready_busy_n
);
   import fcui_pkg::*;

   localparam int SEC_W = ARRAY_BITS - SECT_BITS;

   // ==========================================================
   // Pin synchronisers
   logic [1:0] tbl_sync_ff, wp_sync_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tbl_sync_ff <= 2'b11;
         wp_sync_ff  <= 2'b11;
      end else begin
         tbl_sync_ff <= {tbl_sync_ff[0], top_sector_protect_pin_n};
         wp_sync_ff  <= {wp_sync_ff[0], other_sector_protect_pin_n};
      end
   end

   // ==========================================================
   // Storage: flash array modelled as a byte array
   logic [7:0] mem_ff [0:(1<<ARRAY_BITS)-1];

   // ==========================================================
   // APB decode
   logic        wr_en, rd_en;
   logic [7:0]  cmd_byte;
   logic        mapped;
   assign wr_en    = psel && penable && pwrite;
   assign rd_en    = psel && penable && !pwrite;
   assign cmd_byte = pwdata[7:0];
   assign pready   = 1'b1;
   assign mapped   = (paddr == REG_CMD) || (paddr == REG_ADDR) || (paddr == REG_DATA) ||
                     (paddr == REG_LOCK) || (paddr == REG_STATUS) || (paddr == REG_MODE);
   assign pslverr  = psel && penable && !mapped;

   logic [ARRAY_BITS-1:0] addr_ff;
   logic [SECTORS-1:0]    lock_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) addr_ff <= '0;
      else if (wr_en && paddr == REG_ADDR) addr_ff <= pwdata[ARRAY_BITS-1:0];
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) lock_ff <= LOCK_RESET[SECTORS-1:0];
      else if (wr_en && paddr == REG_LOCK) lock_ff <= pwdata[SECTORS-1:0];
   end

   // A command write is a write of the command register; the command byte is pwdata[7:0]
   logic cmd_wr;
   assign cmd_wr = wr_en && paddr == REG_CMD;

   // ==========================================================
   // Command decoder and write state machine
   fcui_rmode_e rmode_ff;
   fcui_wsm_e   wsm_ff;
   logic        erase_pend_ff, prog_pend_ff, susp_req_ff;
   logic        esusp_ff, psusp_ff, nest_prog_ff, resume_pend_ff;
   logic [SEC_W-1:0]      erase_sec_ff;
   logic [ARRAY_BITS-1:0] prog_addr_ff;
   logic [7:0]            prog_data_ff;
   logic [15:0]           cnt_ff;
   logic        err_erase_ff, err_prog_ff, err_prot_ff;
   logic [ARRAY_BITS-1:0] e_addr_ff;

   logic busy;
   assign busy = (wsm_ff == FCUI_W_PROG) || (wsm_ff == FCUI_W_ERASE);

   function automatic logic sec_locked(input logic [ARRAY_BITS-1:0] a);
      logic [SEC_W-1:0] s;
      s = a[ARRAY_BITS-1:SECT_BITS];
      if (lock_ff[s]) return 1'b1;
      if (s == SEC_W'(SECTORS-1)) return !tbl_sync_ff[1];
      return !wp_sync_ff[1];
   endfunction

   logic set_seq_err, set_prot, set_prog_err, clr_err;
   logic start_prog, start_erase;
   logic [ARRAY_BITS-1:0] cmd_addr;
   assign cmd_addr = addr_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rmode_ff      <= FCUI_RD_ARRAY;
         erase_pend_ff <= 1'b0;
         prog_pend_ff  <= 1'b0;
      end else if (cmd_wr) begin
         if (erase_pend_ff || prog_pend_ff) begin
            erase_pend_ff <= 1'b0;
            prog_pend_ff  <= 1'b0;
            rmode_ff      <= FCUI_RD_STATUS;
         end else begin
            case (cmd_byte)
               CMD_READ_ARRAY: if (!busy) rmode_ff <= FCUI_RD_ARRAY;
               CMD_READ_STATUS: rmode_ff <= FCUI_RD_STATUS;
               CMD_READ_ID: if (wsm_ff == FCUI_W_IDLE) rmode_ff <= FCUI_RD_ID;
               CMD_ERASE_SETUP: if (wsm_ff == FCUI_W_IDLE) erase_pend_ff <= 1'b1;
               CMD_PROG_SETUP_A, CMD_PROG_SETUP_B:
                  if (wsm_ff == FCUI_W_IDLE || wsm_ff == FCUI_W_ESUSP)
                     prog_pend_ff <= 1'b1;
               CMD_SUSPEND, CMD_CONFIRM, CMD_CLEAR_STATUS:
                  rmode_ff <= FCUI_RD_STATUS;
               default: rmode_ff <= FCUI_RD_STATUS;
            endcase
         end
      end
   end

   // Command classification for the write state machine
   always_comb begin
      set_seq_err = 1'b0;
      start_prog  = 1'b0;
      start_erase = 1'b0;
      clr_err     = 1'b0;
      if (cmd_wr) begin
         if (erase_pend_ff) begin
            if (cmd_byte == CMD_CONFIRM) start_erase = 1'b1;
            else set_seq_err = 1'b1;
         end else if (prog_pend_ff) begin
            start_prog = 1'b1;
         end else if (cmd_byte == CMD_CLEAR_STATUS) begin
            clr_err = 1'b1;
         end
      end
   end

   // Protection check at start, sampled once for the whole operation
   assign set_prot = (start_erase && sec_locked(cmd_addr)) ||
                     (start_prog && (sec_locked(cmd_addr) ||
                      (esusp_ff && cmd_addr[ARRAY_BITS-1:SECT_BITS] == erase_sec_ff)));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wsm_ff         <= FCUI_W_IDLE;
         cnt_ff         <= '0;
         susp_req_ff    <= 1'b0;
         esusp_ff       <= 1'b0;
         psusp_ff       <= 1'b0;
         nest_prog_ff   <= 1'b0;
         resume_pend_ff <= 1'b0;
         erase_sec_ff   <= '0;
         prog_addr_ff   <= '0;
         prog_data_ff   <= '0;
         e_addr_ff      <= '0;
      end else begin
         case (wsm_ff)
            FCUI_W_IDLE, FCUI_W_ESUSP: begin
               if (start_prog && !set_prot) begin
                  prog_addr_ff <= cmd_addr;
                  prog_data_ff <= cmd_byte;
                  cnt_ff       <= 16'(PROG_CYC);
                  nest_prog_ff <= (wsm_ff == FCUI_W_ESUSP);
                  wsm_ff       <= FCUI_W_PROG;
               end else if (wsm_ff == FCUI_W_IDLE && start_erase && !set_prot) begin
                  erase_sec_ff <= cmd_addr[ARRAY_BITS-1:SECT_BITS];
                  e_addr_ff    <= {cmd_addr[ARRAY_BITS-1:SECT_BITS], {SECT_BITS{1'b0}}};
                  cnt_ff       <= 16'(ERASE_CYC);
                  wsm_ff       <= FCUI_W_ERASE;
               end else if (wsm_ff == FCUI_W_ESUSP && cmd_wr && cmd_byte == CMD_CONFIRM
                            && !prog_pend_ff) begin
                  esusp_ff <= 1'b0;
                  wsm_ff   <= FCUI_W_ERASE;
               end
            end
            FCUI_W_PROG: begin
               if (cmd_wr && cmd_byte == CMD_SUSPEND && !nest_prog_ff) susp_req_ff <= 1'b1;
               if (susp_req_ff && cnt_ff[1:0] == 2'b00) begin
                  susp_req_ff <= 1'b0;
                  psusp_ff    <= 1'b1;
                  wsm_ff      <= FCUI_W_PSUSP;
               end else if (cnt_ff <= 16'd1) begin
                  // Pulse done: only 1->0 transitions take effect
                  mem_ff[prog_addr_ff] <= mem_ff[prog_addr_ff] & prog_data_ff;
                  // A late suspend request must not carry over into the next operation
                  susp_req_ff  <= 1'b0;
                  nest_prog_ff <= 1'b0;
                  wsm_ff <= nest_prog_ff ? FCUI_W_ESUSP : FCUI_W_IDLE;
               end else begin
                  cnt_ff <= cnt_ff - 16'd1;
               end
            end
            FCUI_W_PSUSP: begin
               if (cmd_wr && cmd_byte == CMD_CONFIRM) begin
                  psusp_ff <= 1'b0;
                  wsm_ff   <= FCUI_W_PROG;
               end
            end
            FCUI_W_ERASE: begin
               if (cmd_wr && cmd_byte == CMD_SUSPEND) susp_req_ff <= 1'b1;
               // Suspend only at step boundaries so a partial cell write never stalls
               if (susp_req_ff && cnt_ff[1:0] == 2'(SUSP_STEP-4)) begin
                  susp_req_ff <= 1'b0;
                  esusp_ff    <= 1'b1;
                  wsm_ff      <= FCUI_W_ESUSP;
               end else if (e_addr_ff[SECT_BITS-1:0] != {SECT_BITS{1'b1}} || cnt_ff > 16'd1) begin
                  mem_ff[e_addr_ff] <= 8'hFF;
                  if (e_addr_ff[SECT_BITS-1:0] != {SECT_BITS{1'b1}})
                     e_addr_ff <= e_addr_ff + 1'b1;
                  if (cnt_ff > 16'd1) cnt_ff <= cnt_ff - 16'd1;
               end else begin
                  mem_ff[e_addr_ff] <= 8'hFF;
                  susp_req_ff <= 1'b0;
                  wsm_ff <= FCUI_W_IDLE;
               end
            end
            default: wsm_ff <= FCUI_W_IDLE;
         endcase
      end
   end

   // Verify: error only when a wanted zero stays one
   logic prog_done, verify_fail;
   assign prog_done   = (wsm_ff == FCUI_W_PROG) && !(susp_req_ff && cnt_ff[1:0] == 2'b00) &&
                        cnt_ff <= 16'd1;
   assign verify_fail = prog_done && |((mem_ff[prog_addr_ff] & prog_data_ff) & ~prog_data_ff);
   assign set_prog_err = verify_fail;

   // ==========================================================
   // Error flags: set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_erase_ff <= 1'b0;
         err_prog_ff  <= 1'b0;
         err_prot_ff  <= 1'b0;
      end else begin
         err_erase_ff <= (err_erase_ff && !clr_err) || set_seq_err ||
                         (set_prot && start_erase);
         err_prog_ff  <= (err_prog_ff && !clr_err) || set_seq_err || set_prog_err ||
                         (set_prot && start_prog);
         err_prot_ff  <= (err_prot_ff && !clr_err) || set_prot;
      end
   end

   logic [7:0] status;
   always_comb begin
      status = 8'h00;
      status[ST_READY]      = !busy;
      status[ST_ERASE_SUSP] = esusp_ff;
      status[ST_ERASE_ERR]  = err_erase_ff;
      status[ST_PROG_ERR]   = err_prog_ff;
      status[ST_PROG_SUSP]  = psusp_ff;
      status[ST_PROTECT]    = err_prot_ff;
   end

   // ==========================================================
   // Read path
   logic [7:0] data_view;
   always_comb begin
      case (rmode_ff)
         FCUI_RD_ARRAY:  data_view = mem_ff[addr_ff];
         FCUI_RD_STATUS: data_view = status;
         FCUI_RD_ID:     data_view = (addr_ff == ID_ADDR_MAKER) ? ID_CODE_MAKER :
                                     (addr_ff == ID_ADDR_DEVICE) ? ID_CODE_DEVICE : 8'h00;
         default:        data_view = status;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata <= '0;
      else if (psel && !penable && !pwrite) begin
         case (paddr)
            REG_DATA:   prdata <= {24'h00_0000, data_view};
            REG_ADDR:   prdata <= 32'(addr_ff);
            REG_LOCK:   prdata <= 32'(lock_ff);
            REG_STATUS: prdata <= {24'h00_0000, status};
            REG_MODE:   prdata <= {26'h000_0000, 3'(wsm_ff), 3'(rmode_ff)};
            default:    prdata <= '0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ready_busy_n <= 1'b1;
      else ready_busy_n <= !busy;
   end
endmodule

// *** fcui_pkg.sv ***
package fcui_pkg;
   // ==========================================================
   // Command codes
   localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
   localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
   localparam logic [7:0] CMD_CONFIRM      = 8'hD0;
   localparam logic [7:0] CMD_PROG_SETUP_A = 8'h40;
   localparam logic [7:0] CMD_PROG_SETUP_B = 8'h10;
   localparam logic [7:0] CMD_SUSPEND      = 8'hB0;
   localparam logic [7:0] CMD_READ_ID      = 8'h90;
   localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   // ==========================================================
   // Identifier addresses and codes (code values are arbitrary)
   localparam logic [19:0] ID_ADDR_MAKER  = 20'h0_0000;
   localparam logic [19:0] ID_ADDR_DEVICE = 20'h0_0001;
   localparam logic [7:0]  ID_CODE_MAKER  = 8'h5A;
   localparam logic [7:0]  ID_CODE_DEVICE = 8'hA5;
   // ==========================================================
   // Status bit positions
   localparam int ST_READY      = 7;
   localparam int ST_ERASE_SUSP = 6;
   localparam int ST_ERASE_ERR  = 5;
   localparam int ST_PROG_ERR   = 4;
   localparam int ST_PROG_SUSP  = 2;
   localparam int ST_PROTECT    = 1;
   // ==========================================================
   // APB register map (byte addresses)
   localparam logic [7:0] REG_CMD    = 8'h00;
   localparam logic [7:0] REG_ADDR   = 8'h04;
   localparam logic [7:0] REG_DATA   = 8'h08;
   localparam logic [7:0] REG_LOCK   = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_MODE   = 8'h14;
   // ==========================================================
   // Timing
   localparam int CLK_NS     = 100;
   localparam int PROG_NS    = 2000;
   localparam int ERASE_NS   = 20000;
   localparam int PROG_CYC   = (PROG_NS + CLK_NS - 1) / CLK_NS;
   localparam int ERASE_CYC  = (ERASE_NS + CLK_NS - 1) / CLK_NS;
   localparam int SUSP_STEP  = 4;
   localparam logic [15:0] LOCK_RESET = 16'hFFFF;

   typedef enum logic [2:0] {FCUI_RD_ARRAY, FCUI_RD_STATUS, FCUI_RD_ID} fcui_rmode_e;
   typedef enum logic [2:0] {FCUI_W_IDLE, FCUI_W_PROG, FCUI_W_ERASE, FCUI_W_ESUSP,
                             FCUI_W_PSUSP, FCUI_W_PINS} fcui_wsm_e;
endpackage

// *** fcui_props.sv ***
module fcui_props
   import fcui_pkg::*;
#(
   parameter int SECTORS    = 16,
   parameter int SECT_BITS  = 16,
   parameter int ARRAY_BITS = 20
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        top_sector_protect_pin_n,
   input wire logic        other_sector_protect_pin_n,
   input wire logic        ready_busy_n
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic acc;
   logic mapped;
   logic rd_st;
   logic wcmd;
   assign acc = psel && penable;
   assign mapped = paddr inside {REG_CMD, REG_ADDR, REG_DATA, REG_LOCK, REG_STATUS, REG_MODE};
   assign rd_st = acc && !pwrite && paddr == REG_STATUS;
   assign wcmd = acc && pwrite && paddr == REG_CMD;
   pready_high_a: assert property (pready) else $error("pready low");
   slverr_map_a: assert property (pslverr == (acc && !mapped)) else $error("pslverr wrong");
   // Read data may only move on the edge that closes a read setup
   rdata_hold_a: assert property (!$past(psel && !penable && !pwrite) |-> $stable(prdata))
      else $error("prdata moved");
   unmapped_zero_a: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   busy_cause_a: assert property ($fell(ready_busy_n) |-> $past(wcmd) || $past(wcmd, 2)
      || $past(wcmd, 3)) else $error("busy without command");
   status_ready_a: assert property (rd_st && ready_busy_n == $past(ready_busy_n)
      |-> prdata[ST_READY] == ready_busy_n) else $error("ready bit wrong");
   status_rsvd_a: assert property (rd_st |-> !prdata[0]) else $error("reserved bit set");
   mode_legal_a: assert property (acc && !pwrite && paddr == REG_MODE
      |-> prdata[2:0] <= 3'h2 && prdata[5:3] <= 3'h5 && prdata[31:8] == 24'h00_0000)
      else $error("mode out of range");
endmodule
bind fcui_top fcui_props #(.SECTORS(SECTORS), .SECT_BITS(SECT_BITS), .ARRAY_BITS(ARRAY_BITS))
   u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .top_sector_protect_pin_n(top_sector_protect_pin_n),
   .other_sector_protect_pin_n(other_sector_protect_pin_n), .ready_busy_n(ready_busy_n));

// *** fcui_host.sv ***
module fcui_host (
   input  wire logic        pclk,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   output logic             rd_valid,
   output logic [31:0]      rd_data
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      psel = 0; penable = 0; pwrite = 0; paddr = 8'h00; pwdata = 32'h0000_0000;
      rd_valid = 0; rd_data = 32'h0000_0000;
   end
   // Result strobe lasts one cycle so each read is compared once
   always @(posedge pclk) if (rd_valid) rd_valid <= 0;
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a;
      // Write data only qualifies writes; reads see a changing pattern
      pwdata <= w ? d : ~pwdata;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      if (!w) begin
         rd_data <= prdata;
         rd_valid <= 1;
      end
      psel <= 0; penable <= 0;
   endtask
endmodule

// *** tb_top.sv ***
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import fcui_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rdy_n, top_n, oth_n, rd_valid;
   logic [7:0]  paddr, d0, d1;
   logic [31:0] pwdata, prdata, rd_data, exp_v;
   logic [31:0] q[$];
   int          n_errors = 0, samples_checked = 0, cyc = 0;
   fcui_top #(.SECTORS(16), .SECT_BITS(4), .ARRAY_BITS(8)) u_dut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .top_sector_protect_pin_n(top_n), .other_sector_protect_pin_n(oth_n),
      .ready_busy_n(rdy_n));
   fcui_host u_host (.pclk(pclk), .pready(pready), .prdata(prdata), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .rd_valid(rd_valid), .rd_data(rd_data));
   initial pclk = 0;
   always #50 pclk = ~pclk;
   task automatic complete_run;
      $display("checked %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Ceiling far above the roughly 830 cycles the sequence needs
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 8000) begin
         n_errors++;
         complete_run;
      end
   end
   always @(posedge pclk) if (rd_valid === 1'b1) begin
      exp_v = q.pop_front();
      `CHK(rd_data, exp_v)
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      u_host.xfer(1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      q.push_back(e);
      u_host.xfer(0, a, 32'h0000_0000);
   endtask
   task automatic cmd(input logic [7:0] a, input logic [7:0] c);
      wr(REG_ADDR, {24'h00_0000, a});
      wr(REG_CMD, {24'h00_0000, c});
   endtask
   task automatic arr(input logic [7:0] a, input logic [7:0] e);
      wr(REG_ADDR, {24'h00_0000, a});
      rd(REG_DATA, {24'h00_0000, e});
   endtask
   task automatic wait_rdy;
      repeat (3) @(posedge pclk);
      while (rdy_n !== 1'b1) @(posedge pclk);
   endtask
   initial begin
      presetn = 0; top_n = 1; oth_n = 1;
      void'($urandom(32'hddd7));
      d0 = 8'($urandom);
      d1 = 8'($urandom);
      repeat (12) @(posedge pclk);
      presetn <= 1;
      rd(REG_MODE, 32'h0000_0000);
      rd(REG_STATUS, 32'h0000_0080);
      rd(REG_LOCK, 32'h0000_FFFF);
      rd(8'h20, 32'h0000_0000);
      cmd(8'h13, CMD_PROG_SETUP_A); cmd(8'h13, 8'h00); wait_rdy;
      rd(REG_STATUS, 32'h0000_0092);
      cmd(8'h13, CMD_CLEAR_STATUS);
      rd(REG_STATUS, 32'h0000_0080);
      wr(REG_LOCK, 32'h0000_0000);
      cmd(8'h17, CMD_ERASE_SETUP); cmd(8'h1C, CMD_CONFIRM); wait_rdy;
      cmd(8'h00, CMD_READ_ARRAY); arr(8'h13, 8'hFF);
      cmd(8'h00, CMD_PROG_SETUP_A); cmd(8'h13, d0); cmd(8'h00, CMD_READ_ARRAY);
      rd(REG_MODE, {26'h0, FCUI_W_PROG, FCUI_RD_STATUS});
      wait_rdy; arr(8'h55, 8'h80);
      cmd(8'h00, CMD_READ_ARRAY); arr(8'h13, d0);
      cmd(8'h13, CMD_PROG_SETUP_B); cmd(8'h13, d1); wait_rdy;
      rd(REG_STATUS, 32'h0000_0080);
      cmd(8'h00, CMD_READ_ARRAY); arr(8'h13, d0 & d1);
      cmd(8'h20, CMD_ERASE_SETUP); cmd(8'h20, CMD_READ_ARRAY); wait_rdy;
      rd(REG_STATUS, 32'h0000_00B0);
      cmd(8'h20, CMD_CLEAR_STATUS); cmd(8'h00, CMD_READ_ID);
      arr(ID_ADDR_MAKER[7:0], ID_CODE_MAKER);
      arr(ID_ADDR_DEVICE[7:0], ID_CODE_DEVICE);
      cmd(8'h01, CMD_READ_STATUS); arr(8'h01, 8'h80);
      cmd(8'h2A, CMD_ERASE_SETUP); cmd(8'h2A, CMD_CONFIRM); cmd(8'h2A, CMD_SUSPEND); wait_rdy;
      rd(REG_STATUS, 32'h0000_00C0);
      cmd(8'h35, CMD_PROG_SETUP_A); cmd(8'h35, d1); wait_rdy;
      rd(REG_STATUS, 32'h0000_00C0);
      cmd(8'h2A, CMD_CONFIRM); wait_rdy;
      rd(REG_STATUS, 32'h0000_0080);
      cmd(8'h00, CMD_READ_ARRAY); arr(8'h2F, 8'hFF);
      cmd(8'h14, CMD_PROG_SETUP_A); cmd(8'h14, 8'h0F); cmd(8'h00, CMD_SUSPEND); wait_rdy;
      rd(REG_STATUS, 32'h0000_0084);
      cmd(8'h00, CMD_READ_ARRAY); arr(8'h2F, 8'hFF);
      cmd(8'h00, CMD_CONFIRM); wait_rdy;
      rd(REG_STATUS, 32'h0000_0080);
      cmd(8'h00, CMD_READ_ARRAY); arr(8'h14, 8'h0F);
      @(posedge pclk) top_n <= 0;
      cmd(8'hF4, CMD_ERASE_SETUP); cmd(8'hF4, CMD_CONFIRM); wait_rdy;
      rd(REG_STATUS, 32'h0000_00A2);
      @(posedge pclk) top_n <= 1;
      oth_n <= 0;
      cmd(8'h13, CMD_PROG_SETUP_B); cmd(8'h13, 8'h00); wait_rdy;
      rd(REG_STATUS, 32'h0000_00B2);
      repeat (3) @(posedge pclk);
      complete_run;
   end
endmodule
